/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import thcs_pkg::*;
    typedef struct {
        logic [7:0] i;
        logic [7:0] w;
        logic [7:0] e;
        logic [1:0] p;
    } thcs_row_t;
    logic clk = '0, rst_b = '0, ce = '1, go = '0, lost = '0, fhigh = '0;
    logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [15:0] zi = '0, li = '0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata;
    logic [7:0] d;
    thcs_meas_t meas;
    int mismatches = 0, checked = 0, k;
    thcs_row_t rows [9] = '{
        '{8'h18, 8'h5a, 8'h5a, THCS_RESP_OKAY}, '{8'h19, 8'h01, 8'h01, THCS_RESP_OKAY},
        '{8'h16, 8'h34, 8'h34, THCS_RESP_OKAY}, '{8'h17, 8'h02, 8'h02, THCS_RESP_OKAY},
        '{8'h0a, 8'h08, 8'h08, THCS_RESP_OKAY}, '{8'h40, 8'h80, 8'h00, THCS_RESP_OKAY},
        '{8'h41, 8'h10, 8'h00, THCS_RESP_OKAY}, '{8'h43, 8'h00, 8'h00, THCS_RESP_OKAY},
        '{8'h3c, 8'h55, 8'h00, THCS_RESP_SLVERR}};
    always #50 clk = ~clk;
    thcs_top u_dut (.clk, .rst_b, .ce, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready,
        .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
        .rvalid, .rready, .rdata, .rresp, .meas, .irq);
    thcs_conv_model u_conv (.clk, .go, .imp(zi), .ind(li), .lost, .fhigh, .meas);
    ////////////////////////////////////////
    task print_verdict;
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tmo(input int n);
        if (n >= 99) begin
            mismatches++;
            print_verdict;
        end
    endtask
    task wr(input logic [7:0] i, input logic [7:0] v);
        int n;
        logic a, w;
        awaddr <= {2'h0, i, 2'h0};
        wdata <= {24'h0, v};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        a = 1'h0;
        w = 1'h0;
        for (n = 0; n < 99 && !(a && w); n++) begin
            @(posedge clk);
            a = a | awready;
            w = w | wready;
            if (a) awvalid <= 1'h0;
            if (w) wvalid <= 1'h0;
        end
        tmo(n);
        for (n = 0; n < 99 && bvalid !== 1'h1; n++) @(posedge clk);
        tmo(n);
        r = bresp;
        bready <= 1'h0;
        @(posedge clk);
    endtask
    task rd(input logic [7:0] i);
        int n;
        araddr <= {2'h0, i, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 99 && arready !== 1'h1; n++) @(posedge clk);
        tmo(n);
        if (n == 0) @(posedge clk);
        arvalid <= 1'h0;
        for (n = 0; n < 99 && rvalid !== 1'h1; n++) @(posedge clk);
        tmo(n);
        d = rdata[7:0];
        r = rresp;
        rready <= 1'h0;
        @(posedge clk);
    endtask
    task st(input logic [7:0] m, input logic [7:0] e);
        rd(THCS_IDX_STAT);
        chk(d & m, e);
    endtask
    task poll;
        int n;
        for (n = 0; n < 99; n++) begin
            rd(THCS_IDX_STAT);
            if (d[0] === 1'h0) break;
        end
        tmo(n);
    endtask
    task put(input logic [15:0] z, input logic [15:0] l);
        zi <= z;
        li <= l;
        go <= 1'h1;
        @(posedge clk);
        go <= 1'h0;
        repeat (2) @(posedge clk);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'h1;
        @(posedge clk);
        poll;
        for (k = 0; k < 9; k++) begin
            wr(rows[k].i, rows[k].w);
            chk({6'h0, r}, {6'h0, rows[k].p});
            rd(rows[k].i);
            chk(d, rows[k].e);
            chk({6'h0, r}, {6'h0, rows[k].p});
        end
        put(16'h5, 16'h235);
        st(8'hff, 8'h30);
        put(16'h5, 16'h200);
        st(8'hff, 8'h30);
        put(16'h5, 16'h159);
        st(8'hff, 8'h34);
        put(16'h5, 16'h15a);
        st(8'hff, 8'h34);
        put(16'h5, 16'h300);
        wr(8'h18, 8'h70);
        put(16'h5, 16'h160);
        st(8'hff, 8'h30);
        wr(8'h19, 8'h01);
        put(16'h5, 16'h160);
        st(8'hff, 8'h34);
        wr(THCS_IDX_ISEL, THCS_ISEL_CLEAR);
        wr(THCS_IDX_ISEL, 8'h08);
        st(8'hff, 8'h7c);
        wr(THCS_IDX_ISEL, 8'h01);
        put(16'h81, 16'h200);
        st(8'hff, 8'h0c);
        put(16'hf, 16'h200);
        st(8'hff, 8'h1c);
        wr(THCS_IDX_ISEL, 8'h08);
        st(8'hff, 8'h7c);
        wr(THCS_IDX_ISEL, 8'h01);
        st(8'hff, 8'h5c);
        ce <= 1'h0;
        put(16'h5, 16'h300);
        ce <= 1'h1;
        st(8'h0c, 8'h0c);
        lost <= 1'h1;
        repeat (4) @(posedge clk);
        st(8'h80, 8'h80);
        lost <= 1'h0;
        fhigh <= 1'h1;
        repeat (4) @(posedge clk);
        st(8'h80, 8'h80);
        fhigh <= 1'h0;
        repeat (4) @(posedge clk);
        st(8'h80, 8'h00);
        wr(THCS_IDX_IRQ_STAT, 8'h0f);
        put(16'h5, 16'h200);
        rd(THCS_IDX_IRQ_STAT);
        chk(d & 8'h01, 8'h01);
        chk({7'h0, irq}, 8'h00);
        wr(THCS_IDX_IRQ_MASK, 8'h01);
        @(posedge clk);
        chk({7'h0, irq}, 8'h01);
        wr(THCS_IDX_IRQ_STAT, 8'h01);
        @(posedge clk);
        chk({7'h0, irq}, 8'h00);
        rst_b <= 1'h0;
        repeat (3) @(posedge clk);
        rst_b <= 1'h1;
        @(posedge clk);
        st(8'h01, 8'h01);
        wr(THCS_IDX_LLO_MSB, 8'haa);
        poll;
        rd(THCS_IDX_LLO_MSB);
        chk(d, 8'h00);
        print_verdict;
    end
endmodule

`default_nettype wire

/* File: thcs_conv_model.sv */
`timescale 1ns/1ps
`default_nettype none

module thcs_conv_model (
    // clock
    input wire logic clk,
    // result request
    input wire logic go,
    input wire logic [15:0] imp,
    input wire logic [15:0] ind,
    input wire logic lost,
    input wire logic fhigh,
    // to block
    output var thcs_pkg::thcs_meas_t meas
);
    import thcs_pkg::*;
    // one-cycle result pulse, results scramble between pulses
    always_ff @(posedge clk) begin
        meas.valid <= go;
        meas.impedance_result <= go ? imp : ~meas.impedance_result;
        meas.inductance_result <= go ? ind : ~meas.inductance_result;
        meas.osc_lost <= lost;
        meas.lowest_sensor_frequency_high <= fhigh;
    end
endmodule

`default_nettype wire

/* File: thcs_pkg.sv */
package thcs_pkg;

    // bus shape
    localparam int THCS_ADDR_W = 12;
    localparam int THCS_DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [7:0] THCS_IDX_ISEL = 8'h0a;
    localparam logic [7:0] THCS_IDX_LHI_LSB = 8'h16;
    localparam logic [7:0] THCS_IDX_LHI_MSB = 8'h17;
    localparam logic [7:0] THCS_IDX_LLO_LSB = 8'h18;
    localparam logic [7:0] THCS_IDX_LLO_MSB = 8'h19;
    localparam logic [7:0] THCS_IDX_STAT = 8'h20;
    localparam logic [7:0] THCS_IDX_ZHI = 8'h40;
    localparam logic [7:0] THCS_IDX_ZLO = 8'h41;
    localparam logic [7:0] THCS_IDX_IRQ_STAT = 8'h42;
    localparam logic [7:0] THCS_IDX_IRQ_MASK = 8'h43;

    // reset values and codes
    localparam logic [7:0] THCS_RST_BYTE = 8'h00;
    localparam logic [15:0] THCS_RST_LIMIT = 16'h0000;
    localparam logic [5:0] THCS_RST_ISEL = 6'h00;
    localparam logic [7:0] THCS_ISEL_CLEAR = 8'h00;
    localparam logic [5:0] THCS_SEL_Z_OVER = 6'h01;
    localparam logic [5:0] THCS_SEL_L_OVER = 6'h08;
    localparam logic [1:0] THCS_RESP_OKAY = 2'h0;
    localparam logic [1:0] THCS_RESP_SLVERR = 2'h2;

    // power-on busy time in clock cycles
    localparam int THCS_POR_W = 5;
    localparam logic [THCS_POR_W-1:0] THCS_POR_CYCLES = 5'h10;

    // interrupt bit positions
    localparam int THCS_IRQ_N = 4;
    localparam int THCS_IRQ_READY = 0;
    localparam int THCS_IRQ_Z_OVER = 1;
    localparam int THCS_IRQ_L_OVER = 2;
    localparam int THCS_IRQ_OSC = 3;

    // measurement input from the conversion datapath
    typedef struct packed {
        logic valid;
        logic [15:0] impedance_result;
        logic [15:0] inductance_result;
        logic osc_lost;
        logic lowest_sensor_frequency_high;
    } thcs_meas_t;

    // whole state of the block
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_got;
        logic [7:0] waddr;
        logic w_got;
        logic [7:0] wbyte;
        logic wen;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rbyte;
        logic [7:0] l_lo_buf;
        logic [15:0] inductance_low_limit;
        logic [7:0] l_hi_buf;
        logic [15:0] inductance_high_limit;
        logic [15:0] impedance_high_limit;
        logic [15:0] impedance_low_limit;
        logic [5:0] interrupt_source_select;
        logic result_ready_n;
        logic impedance_over_flag_n;
        logic impedance_window_flag;
        logic inductance_over_flag_n;
        logic inductance_window_flag;
        logic oscillation_missing_error;
        logic [THCS_POR_W-1:0] por_cnt;
        logic [THCS_IRQ_N-1:0] irq_stat;
        logic [THCS_IRQ_N-1:0] irq_mask;
        logic irq;
    } thcs_state_t;

endpackage

/* File: thcs_top.sv */
//
// Contract
// - low inductance limit is upper byte times 256 plus lower byte.
// - inductance window flag set when result falls below low limit.
// - low-limit lower byte is buffered until the upper byte is written.
// - upper byte writes are accepted while converting, without stopping conversions.
// - status bit 7 reads 1 when sensor oscillation is not detected.
// - oscillation error also raised when minimum frequency exceeds sensor frequency.
// - status bit 6 reads 0 when new combined result is available.
// - status bit 5 latches 0 once impedance exceeds its high limit.
// - writing 0x00 to interrupt select register clears the latched over flags.
// - over flags reported only for matching interrupt select codes.
// - status bit 3 latches 0 once inductance exceeds its high limit.
// - status bit 4 goes 0 above impedance high, 1 below impedance low.
// - status bit 2 goes 0 above inductance high, 1 below inductance low.
// - status bit 0 reads 1 while power-on reset is in progress.
// - configuration writes are ignored during power-on reset.
// - inductance over flag set when result exceeds high limit.
// - high-limit lower byte is buffered until the upper byte is written.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module thcs_top (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [thcs_pkg::THCS_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [thcs_pkg::THCS_DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [thcs_pkg::THCS_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [thcs_pkg::THCS_DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    // conversion datapath
    input wire thcs_pkg::thcs_meas_t meas,
    // interrupt
    output logic irq
);
    import thcs_pkg::*;

    thcs_state_t s_q;
    thcs_state_t s_d;

    ////////////////////////////////////////////////////////////////////////////
    // register map helpers

    function automatic logic idx_known(input logic [7:0] idx);
        logic hit;
        hit = 1'b0;
        case (idx)
            THCS_IDX_ISEL, THCS_IDX_LHI_LSB, THCS_IDX_LHI_MSB,
            THCS_IDX_LLO_LSB, THCS_IDX_LLO_MSB, THCS_IDX_STAT,
            THCS_IDX_ZHI, THCS_IDX_ZLO, THCS_IDX_IRQ_STAT,
            THCS_IDX_IRQ_MASK: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    function automatic logic [7:0] status_byte(input thcs_state_t s);
        logic z_rep;
        logic l_rep;
        z_rep = s.impedance_over_flag_n | (s.interrupt_source_select != THCS_SEL_Z_OVER);
        l_rep = s.inductance_over_flag_n | (s.interrupt_source_select != THCS_SEL_L_OVER);
        return {s.oscillation_missing_error,
                s.result_ready_n,
                z_rep,
                s.impedance_window_flag,
                l_rep,
                s.inductance_window_flag,
                1'b0,
                (s.por_cnt != '0)};
    endfunction

    function automatic logic [7:0] read_byte(input thcs_state_t s, input logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            THCS_IDX_ISEL: v = {2'h0, s.interrupt_source_select};
            THCS_IDX_LHI_LSB: v = s.l_hi_buf;
            THCS_IDX_LHI_MSB: v = s.inductance_high_limit[15:8];
            THCS_IDX_LLO_LSB: v = s.l_lo_buf;
            THCS_IDX_LLO_MSB: v = s.inductance_low_limit[15:8];
            THCS_IDX_STAT: v = status_byte(s);
            THCS_IDX_IRQ_STAT: v = {4'h0, s.irq_stat};
            THCS_IDX_IRQ_MASK: v = {4'h0, s.irq_mask};
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state

    logic por_busy;
    logic [7:0] ridx;
    logic [15:0] zrd;
    logic [THCS_IRQ_N-1:0] ev;
    logic osc_now;

    always_comb begin
        s_d = s_q;
        por_busy = (s_q.por_cnt != '0);
        ridx = araddr[9:2];
        zrd = 16'h0000;
        ev = '0;
        osc_now = meas.osc_lost | meas.lowest_sensor_frequency_high;

        // power-on busy countdown
        if (por_busy) begin
            s_d.por_cnt = s_q.por_cnt - 1'b1;
        end

        // write address and data, taken in either order
        if (s_q.awready && awvalid) begin
            s_d.awready = 1'b0;
            s_d.aw_got = 1'b1;
            s_d.waddr = awaddr[9:2];
        end
        if (s_q.wready && wvalid) begin
            s_d.wready = 1'b0;
            s_d.w_got = 1'b1;
            s_d.wbyte = wdata[7:0];
            s_d.wen = wstrb[0];
        end

        // perform the write once both halves are in
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = idx_known(s_q.waddr) ? THCS_RESP_OKAY : THCS_RESP_SLVERR;
            if (s_q.wen && !por_busy) begin
                case (s_q.waddr)
                    THCS_IDX_ISEL: begin
                        s_d.interrupt_source_select = s_q.wbyte[5:0];
                        if (s_q.wbyte == THCS_ISEL_CLEAR) begin
                            s_d.impedance_over_flag_n = 1'b1;
                            s_d.inductance_over_flag_n = 1'b1;
                        end
                    end
                    THCS_IDX_LHI_LSB: s_d.l_hi_buf = s_q.wbyte;
                    THCS_IDX_LHI_MSB: s_d.inductance_high_limit = {s_q.wbyte, s_q.l_hi_buf};
                    THCS_IDX_LLO_LSB: s_d.l_lo_buf = s_q.wbyte;
                    THCS_IDX_LLO_MSB: s_d.inductance_low_limit = {s_q.wbyte, s_q.l_lo_buf};
                    THCS_IDX_ZHI: s_d.impedance_high_limit = {8'h00, s_q.wbyte};
                    THCS_IDX_ZLO: s_d.impedance_low_limit = {8'h00, s_q.wbyte};
                    THCS_IDX_IRQ_STAT: s_d.irq_stat = s_q.irq_stat & ~s_q.wbyte[THCS_IRQ_N-1:0];
                    THCS_IDX_IRQ_MASK: s_d.irq_mask = s_q.wbyte[THCS_IRQ_N-1:0];
                    default: s_d.bresp = s_d.bresp;
                endcase
            end
        end

        // write response
        if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
            s_d.awready = 1'b1;
            s_d.wready = 1'b1;
        end

        // read channel
        if (s_q.arready && arvalid) begin
            s_d.arready = 1'b0;
            s_d.rvalid = 1'b1;
            s_d.rbyte = read_byte(s_q, ridx);
            s_d.rresp = idx_known(ridx) ? THCS_RESP_OKAY : THCS_RESP_SLVERR;
            if (ridx == THCS_IDX_STAT) begin
                s_d.result_ready_n = 1'b1;
            end
        end
        if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
            s_d.arready = 1'b1;
        end

        // threshold comparison on each new result; sets override clears
        if (meas.valid) begin
            s_d.result_ready_n = 1'b0;
            ev[THCS_IRQ_READY] = 1'b1;
            if (meas.inductance_result > s_q.inductance_high_limit) begin
                s_d.inductance_over_flag_n = 1'b0;
                s_d.inductance_window_flag = 1'b0;
                ev[THCS_IRQ_L_OVER] = s_q.inductance_over_flag_n;
            end else if (meas.inductance_result < s_q.inductance_low_limit) begin
                s_d.inductance_window_flag = 1'b1;
            end
            if (meas.impedance_result > s_q.impedance_high_limit) begin
                s_d.impedance_over_flag_n = 1'b0;
                s_d.impedance_window_flag = 1'b0;
                ev[THCS_IRQ_Z_OVER] = s_q.impedance_over_flag_n;
            end else if (meas.impedance_result < s_q.impedance_low_limit) begin
                s_d.impedance_window_flag = 1'b1;
            end
        end

        // oscillation error follows the datapath level
        s_d.oscillation_missing_error = osc_now;
        ev[THCS_IRQ_OSC] = osc_now & ~s_q.oscillation_missing_error;

        // sticky interrupt status and output
        s_d.irq_stat = s_d.irq_stat | ev;
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
        zrd = {8'h00, s_d.rbyte};
        s_d.rbyte = zrd[7:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.awready <= 1'b1;
            s_q.wready <= 1'b1;
            s_q.arready <= 1'b1;
            s_q.bresp <= THCS_RESP_OKAY;
            s_q.rresp <= THCS_RESP_OKAY;
            s_q.rbyte <= THCS_RST_BYTE;
            s_q.l_lo_buf <= THCS_RST_BYTE;
            s_q.l_hi_buf <= THCS_RST_BYTE;
            s_q.inductance_low_limit <= THCS_RST_LIMIT;
            s_q.inductance_high_limit <= THCS_RST_LIMIT;
            s_q.impedance_low_limit <= THCS_RST_LIMIT;
            s_q.impedance_high_limit <= THCS_RST_LIMIT;
            s_q.interrupt_source_select <= THCS_RST_ISEL;
            s_q.result_ready_n <= 1'b1;
            s_q.impedance_over_flag_n <= 1'b1;
            s_q.inductance_over_flag_n <= 1'b1;
            s_q.por_cnt <= THCS_POR_CYCLES;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign awready = s_q.awready;
    assign wready = s_q.wready;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign arready = s_q.arready;
    assign rvalid = s_q.rvalid;
    assign rresp = s_q.rresp;
    assign rdata = {24'h000000, s_q.rbyte};
    assign irq = s_q.irq;

endmodule

`default_nettype wire

/* File: thcs_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module thcs_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [thcs_pkg::THCS_ADDR_W-1:0] araddr,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [thcs_pkg::THCS_DATA_W-1:0] rdata
);
    import thcs_pkg::*;
    logic [7:0] idx_q;
    logic [4:0] cyc_q;
    logic is_stat;
    ////////////////////////////////////////
    // read index and cycles since reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            idx_q <= 8'h0;
            cyc_q <= 5'h0;
        end else begin
            if (arvalid && arready) idx_q <= araddr[9:2];
            if (cyc_q != 5'h1f) cyc_q <= cyc_q + 5'h1;
        end
    end
    assign is_stat = rvalid && idx_q == THCS_IDX_STAT;
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////
    aw_take_a: assert property (awvalid && awready && wvalid && wready |=> !awready && !wready)
        else $error("write channels not closed");
    write_resp_a: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
        else $error("write response late");
    b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    read_resp_a: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read response late");
    r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    upper_zero_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    por_busy_a: assert property (is_stat && cyc_q < 5'h8 |-> rdata[0])
        else $error("busy bit low too early");
    por_done_a: assert property (is_stat && cyc_q > 5'h18 |-> !rdata[0])
        else $error("busy bit stuck");
    stat_spare_a: assert property (is_stat |-> !rdata[1])
        else $error("spare status bit set");
endmodule

bind thcs_top thcs_chk u_chk (.clk, .rst_b, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
    .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata);

`default_nettype wire
